// ===== src/spi_rx_status.sv
/*
 * Receive read mode, transmit and receive FIFOs, status and interrupt registers of
 * the serial unit. Assumes the serial engine sits on the same clock, pushes received
 * words through the receive handshake, pops words to send, and reports its activity.
 */
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - With protect set, a data read returns the oldest entry and keeps the pointer.
// - Writing one to pop bit 0 drops the oldest receive entry, pointer plus one.
// - With protect clear, the reset state, each data read returns and removes an entry.
// - A write to the data register pushes the value into the transmit FIFO.
// - Unused bits of read-mode and status registers read as zero.
// - Status bit 5 is high while sending in sequential-slave mode, else low.
// - Status bit 4 is high while transferring or transmit FIFO is not empty.
// - Status bit 3 shows receive FIFO full; resets to zero.
// - Status bit 2 shows receive FIFO empty; resets to one.
// - Status bit 1 shows transmit FIFO full; resets to zero.
// - Status bit 0 shows transmit FIFO empty; resets to one.
module spi_rx_status #(
    parameter int unsigned DATA_W = spi_rx_status_pkg::DATA_W,
    parameter int unsigned DEPTH  = spi_rx_status_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_n,
    // Register port
    input  wire logic [7:0]        i_addr,
    input  wire logic [31:0]       i_wr_data,
    input  wire logic              i_wr_stb,
    input  wire logic              i_rd_stb,
    output logic      [31:0]       o_rd_data,
    // Receive words from the serial engine
    input  wire logic              i_rx_push,
    input  wire logic [DATA_W-1:0] i_rx_data,
    output logic                   o_rx_ready,
    // Transmit words to the serial engine
    input  wire logic              i_tx_pop,
    output logic                   o_tx_avail,
    output logic      [DATA_W-1:0] o_tx_data,
    output logic                   o_tx_data_valid,
    // Engine activity
    input  wire logic              i_xfer_active,
    input  wire logic              i_seq_mode,
    // Interrupt
    output logic                   o_irq
);

    localparam int unsigned AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || DATA_W < 1 || DATA_W > 32) begin : g_bad_size
            $error("FIFO depth must be a power of two of at least 2, width 1 to 32");
        end
    endgenerate

    function automatic logic ptr_full(input logic [AW:0] wr, input logic [AW:0] rd);
        ptr_full = (wr[AW] != rd[AW]) && (wr[AW-1:0] == rd[AW-1:0]);
    endfunction : ptr_full

    // Register state
    logic                                        protect_r;
    logic [spi_rx_status_pkg::INT_BITS-1:0]      int_stat_r;
    logic [spi_rx_status_pkg::INT_BITS-1:0]      int_mask_r;
    logic [31:0]                                 rd_data_r;
    logic                                        rd_fifo_r;
    logic                                        tx_valid_r;
    // FIFO pointers
    logic [AW:0]                                 rx_wr_ptr_r;
    logic [AW:0]                                 rx_rd_ptr_r;
    logic [AW:0]                                 tx_wr_ptr_r;
    logic [AW:0]                                 tx_rd_ptr_r;
    logic [AW:0]                                 rx_rd_ptr_nxt;
    logic [AW:0]                                 tx_rd_ptr_nxt;

    // Address decode
    wire sel_data   = (i_addr == spi_rx_status_pkg::OFF_FIFO_DATA);
    wire sel_pop    = (i_addr == spi_rx_status_pkg::OFF_RX_POP);
    wire sel_mode   = (i_addr == spi_rx_status_pkg::OFF_READ_MODE);
    wire sel_status = (i_addr == spi_rx_status_pkg::OFF_STATUS);
    wire sel_istat  = (i_addr == spi_rx_status_pkg::OFF_INT_STATUS);
    wire sel_imask  = (i_addr == spi_rx_status_pkg::OFF_INT_MASK);

    // FIFO flags
    wire rx_empty = (rx_wr_ptr_r == rx_rd_ptr_r);
    wire rx_full  = ptr_full(rx_wr_ptr_r, rx_rd_ptr_r);
    wire tx_empty = (tx_wr_ptr_r == tx_rd_ptr_r);
    wire tx_full  = ptr_full(tx_wr_ptr_r, tx_rd_ptr_r);

    // Receive side: engine push, bus read or pop
    wire rx_push_ok = i_rx_push && !rx_full;
    wire rx_overrun = i_rx_push && rx_full;
    wire data_read  = i_rd_stb && sel_data;
    wire pop_write  = i_wr_stb && sel_pop && i_wr_data[spi_rx_status_pkg::BIT_POP];
    wire read_pops  = data_read && !protect_r;
    wire rx_advance = !rx_empty && (read_pops || pop_write);

    // Transmit side: bus write and engine pop
    wire tx_write   = i_wr_stb && sel_data;
    wire tx_push_ok = tx_write && !tx_full;
    wire tx_overrun = tx_write && tx_full;
    wire tx_pop_ok  = i_tx_pop && !tx_empty;
    wire tx_drained = tx_pop_ok && !tx_push_ok && (tx_rd_ptr_nxt == tx_wr_ptr_r);

    assign rx_rd_ptr_nxt = rx_advance ? rx_rd_ptr_r + 1'b1 : rx_rd_ptr_r;
    assign tx_rd_ptr_nxt = tx_pop_ok ? tx_rd_ptr_r + 1'b1 : tx_rd_ptr_r;

    // Status word, live every cycle
    wire busy       = i_xfer_active || !tx_empty;
    wire multi_target_active = i_seq_mode && busy;
    wire [spi_rx_status_pkg::STATUS_BITS-1:0] status_bits = {
        multi_target_active,
        busy,
        rx_full,
        rx_empty,
        tx_full,
        tx_empty
    };

    // Interrupt events
    wire [spi_rx_status_pkg::INT_BITS-1:0] int_event = {
        tx_overrun,
        tx_drained,
        rx_overrun,
        rx_push_ok
    };
    wire [spi_rx_status_pkg::INT_BITS-1:0] int_clear =
        (i_wr_stb && sel_istat) ? i_wr_data[spi_rx_status_pkg::INT_BITS-1:0] : '0;
    // Set wins over a clear written in the same cycle
    wire [spi_rx_status_pkg::INT_BITS-1:0] int_stat_nxt = (int_stat_r & ~int_clear) | int_event;

    // Read mux; unused and unmapped bits read as zero
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        if (sel_mode) begin
            rd_word[spi_rx_status_pkg::BIT_PROTECT] = protect_r;
        end else if (sel_status) begin
            rd_word[spi_rx_status_pkg::STATUS_BITS-1:0] = status_bits;
        end else if (sel_istat) begin
            rd_word[spi_rx_status_pkg::INT_BITS-1:0] = int_stat_r;
        end else if (sel_imask) begin
            rd_word[spi_rx_status_pkg::INT_BITS-1:0] = int_mask_r;
        end
    end

    // Control registers; the status offset has no write decode
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            protect_r  <= spi_rx_status_pkg::RST_PROTECT;
            int_mask_r <= spi_rx_status_pkg::RST_INT_MASK;
            int_stat_r <= '0;
        end else begin
            if (i_wr_stb && sel_mode) begin
                protect_r <= i_wr_data[spi_rx_status_pkg::BIT_PROTECT];
            end
            if (i_wr_stb && sel_imask) begin
                int_mask_r <= i_wr_data[spi_rx_status_pkg::INT_BITS-1:0];
            end
            int_stat_r <= int_stat_nxt;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            rd_data_r <= spi_rx_status_pkg::RST_RD_DATA;
            rd_fifo_r <= 1'b0;
        end else begin
            rd_data_r <= i_rd_stb ? rd_word : spi_rx_status_pkg::RST_RD_DATA;
            rd_fifo_r <= data_read;
        end
    end

    // FIFO pointers
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            rx_wr_ptr_r <= '0;
            rx_rd_ptr_r <= '0;
            tx_wr_ptr_r <= '0;
            tx_rd_ptr_r <= '0;
            tx_valid_r  <= 1'b0;
        end else begin
            if (rx_push_ok) begin
                rx_wr_ptr_r <= rx_wr_ptr_r + 1'b1;
            end
            rx_rd_ptr_r <= rx_rd_ptr_nxt;
            if (tx_push_ok) begin
                tx_wr_ptr_r <= tx_wr_ptr_r + 1'b1;
            end
            tx_rd_ptr_r <= tx_rd_ptr_nxt;
            tx_valid_r  <= tx_pop_ok;
        end
    end

    logic [DATA_W-1:0] rx_q;

    spi_fifo_ram #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_rx_ram (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_wr_en   (rx_push_ok),
        .i_wr_addr (rx_wr_ptr_r[AW-1:0]),
        .i_wr_data (i_rx_data),
        .i_rd_en   (data_read),
        .i_rd_addr (rx_rd_ptr_r[AW-1:0]),
        .o_rd_data (rx_q)
    );

    spi_fifo_ram #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_tx_ram (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_wr_en   (tx_push_ok),
        .i_wr_addr (tx_wr_ptr_r[AW-1:0]),
        .i_wr_data (i_wr_data[DATA_W-1:0]),
        .i_rd_en   (tx_pop_ok),
        .i_rd_addr (tx_rd_ptr_r[AW-1:0]),
        .o_rd_data (o_tx_data)
    );

    // Outputs
    wire [31:0] rx_word = {{(32 - DATA_W){1'b0}}, rx_q};
    assign o_rd_data       = rd_fifo_r ? rx_word : rd_data_r;
    assign o_rx_ready      = !rx_full;
    assign o_tx_avail      = !tx_empty;
    assign o_tx_data_valid = tx_valid_r;
    assign o_irq           = |(int_stat_r & int_mask_r);

    // Checks
    sequence s_data_read;
        i_rd_stb && sel_data;
    endsequence

    sequence s_status_read;
        i_rd_stb && sel_status;
    endsequence

    sequence s_pop_write;
        i_wr_stb && sel_pop && i_wr_data[0];
    endsequence

    a_protect_keeps_ptr: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        s_data_read ##0 (protect_r && !rx_empty && !i_wr_stb)
            |=> rx_rd_ptr_r == $past(rx_rd_ptr_r))
        else $error("protected data read moved the receive read pointer");

    a_pop_advances: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        s_pop_write ##0 !rx_empty
            |=> rx_rd_ptr_r == $past(rx_rd_ptr_r) + 1'b1)
        else $error("pop write did not advance the receive read pointer");

    a_read_pops: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        s_data_read ##0 (!protect_r && !rx_empty)
            |=> (rx_rd_ptr_r == $past(rx_rd_ptr_r) + 1'b1)
                && (o_rd_data == {{(32 - DATA_W){1'b0}},
                    $past(u_rx_ram.mem_r[rx_rd_ptr_r[AW-1:0]])}))
        else $error("unprotected data read did not remove an entry");

    a_tx_push: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_wr_stb && sel_data && !tx_full)
            |=> tx_wr_ptr_r == $past(tx_wr_ptr_r) + 1'b1 ##1 !tx_empty || $past(i_tx_pop))
        else $error("data write did not enter the transmit FIFO");

    a_reserved_zero: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_rd_stb && (sel_mode || sel_status))
            |=> o_rd_data[31:6] == 26'h000_0000 && (!$past(sel_mode) || o_rd_data[5:1] == 5'h00))
        else $error("reserved bits read as non-zero");

    a_multi_busy: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        s_status_read |=> o_rd_data[5] == ($past(i_seq_mode)
            && ($past(i_xfer_active) || !$past(tx_empty))))
        else $error("sequential busy flag wrong");

    a_busy_flag: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        s_status_read |=> o_rd_data[4] == ($past(i_xfer_active) || $past(o_tx_avail)))
        else $error("busy flag wrong");

    a_rx_flags: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        s_status_read |=> o_rd_data[3:2] == {$past(!o_rx_ready),
            $past(rx_wr_ptr_r == rx_rd_ptr_r)})
        else $error("receive flags wrong");

    a_tx_flags: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        s_status_read |=> o_rd_data[1:0] == {$past(tx_full), !$past(o_tx_avail)})
        else $error("transmit flags wrong");

    a_status_ro: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_wr_stb && sel_status)
            |=> protect_r == $past(protect_r) && int_mask_r == $past(int_mask_r))
        else $error("write to status changed a register");

    a_irq_level: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (rx_push_ok && int_mask_r[0] && !(i_wr_stb && sel_imask)) |=> o_irq)
        else $error("unmasked event gave no interrupt");

    // Read data stand for one cycle only, then fall back to zero
    a_rd_data_idle: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_rd_stb |=> o_rd_data == 32'h0000_0000)
        else $error("read data stood longer than one cycle");

    a_reset_state: assert property (
        @(posedge i_sys_clk)
        !i_rst_n |=> rx_empty && tx_empty && !rx_full && !tx_full && !o_irq && !protect_r)
        else $error("state after reset wrong");

    a_tx_pop_data: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_tx_pop && o_tx_avail)
            |=> o_tx_data_valid
                && o_tx_data == $past(u_tx_ram.mem_r[tx_rd_ptr_r[AW-1:0]]))
        else $error("transmit word or valid pulse wrong");

    a_tx_pop_empty: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_tx_pop && !o_tx_avail)
            |=> !o_tx_data_valid && tx_rd_ptr_r == $past(tx_rd_ptr_r))
        else $error("pop of an empty transmit FIFO was taken");

    // A refused push must leave the FIFO alone and flag the overrun
    a_rx_full_drop: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_rx_push && !o_rx_ready)
            |=> rx_wr_ptr_r == $past(rx_wr_ptr_r)
                && int_stat_r[spi_rx_status_pkg::INT_RX_OVERRUN])
        else $error("push into a full receive FIFO was not dropped");

    a_tx_full_drop: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_wr_stb && sel_data && tx_full)
            |=> tx_wr_ptr_r == $past(tx_wr_ptr_r)
                && int_stat_r[spi_rx_status_pkg::INT_TX_OVERRUN])
        else $error("write into a full transmit FIFO was not dropped");

endmodule : spi_rx_status

`default_nettype wire

// ===== src/spi_rx_status_pkg.sv
/*
 * Constants shared by the receive read-mode and status block and its FIFO memory.
 * Assumes a 32-bit register port with byte offsets, one clock and a synchronous reset.
 */
package spi_rx_status_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_FIFO_DATA   = 8'h00;
    localparam logic [7:0] OFF_RX_POP      = 8'h04;
    localparam logic [7:0] OFF_READ_MODE   = 8'h08;
    localparam logic [7:0] OFF_STATUS      = 8'h0c;
    localparam logic [7:0] OFF_INT_STATUS  = 8'h10;
    localparam logic [7:0] OFF_INT_MASK    = 8'h14;

    // Field positions of the read-mode and pop registers
    localparam int unsigned BIT_PROTECT    = 0;
    localparam int unsigned BIT_POP        = 0;

    // Field positions of the status register
    localparam int unsigned BIT_TX_EMPTY   = 0;
    localparam int unsigned BIT_TX_FULL    = 1;
    localparam int unsigned BIT_RX_EMPTY   = 2;
    localparam int unsigned BIT_RX_FULL    = 3;
    localparam int unsigned BIT_BUSY       = 4;
    localparam int unsigned BIT_MULTI      = 5;
    localparam int unsigned STATUS_BITS    = 6;

    // Field positions of the interrupt status and mask registers
    localparam int unsigned INT_RX_AVAIL   = 0;
    localparam int unsigned INT_RX_OVERRUN = 1;
    localparam int unsigned INT_TX_DRAINED = 2;
    localparam int unsigned INT_TX_OVERRUN = 3;
    localparam int unsigned INT_BITS       = 4;

    // Values after reset
    localparam logic                RST_PROTECT  = 1'b0;
    localparam logic [INT_BITS-1:0] RST_INT_MASK = 4'h0;
    localparam logic [31:0]         RST_RD_DATA  = 32'h0000_0000;

    // Default sizes
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned FIFO_DEPTH  = 8;
    localparam int unsigned ADDR_W      = 8;

endpackage : spi_rx_status_pkg

// ===== src/spi_fifo_ram.sv
/*
 * Small dual-port memory for one FIFO: one write port, one read port.
 * Assumes the caller keeps the addresses in range; read data come from a register.
 */
`timescale 1ns/10ps
`default_nettype none

module spi_fifo_ram #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW    = 3
) (
    // Clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    // Write port
    input  wire logic             i_wr_en,
    input  wire logic [AW-1:0]    i_wr_addr,
    input  wire logic [WIDTH-1:0] i_wr_data,
    // Read port
    input  wire logic             i_rd_en,
    input  wire logic [AW-1:0]    i_rd_addr,
    output logic      [WIDTH-1:0] o_rd_data
);

    generate
        if (DEPTH < 1 || WIDTH < 1 || (1 << AW) < DEPTH) begin : g_bad_size
            $error("memory depth does not fit the address width");
        end
    endgenerate

    logic [WIDTH-1:0] mem_r [DEPTH];

    always_ff @(posedge i_sys_clk) begin
        if (i_wr_en) begin
            mem_r[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_rd_data <= '0;
        end else if (i_rd_en) begin
            o_rd_data <= mem_r[i_rd_addr];
        end
    end

endmodule : spi_fifo_ram

`default_nettype wire

// ===== test/spi_rx_status_test.sv
/*
 * Self-checking bench for the receive read-mode and status block.
 * Assumes the block is built with a small FIFO depth and the register map of the package.
 */
`timescale 1ns/10ps
`default_nettype none

module spi_rx_status_test;
    localparam int unsigned DW = 16;
    localparam int unsigned DP = 4;
    localparam int unsigned MAX_CYC = 4000;

    logic          i_sys_clk = 1'b0;
    logic          i_rst_n = 1'b0;
    logic [7:0]    i_addr = 8'h00;
    logic [31:0]   i_wr_data = 32'h0000_0000;
    logic          i_wr_stb = 1'b0;
    logic          i_rd_stb = 1'b0;
    logic [31:0]   o_rd_data;
    logic          i_rx_push = 1'b0;
    logic [DW-1:0] i_rx_data = 16'h0000;
    logic          o_rx_ready;
    logic          i_tx_pop = 1'b0;
    logic          o_tx_avail;
    logic [DW-1:0] o_tx_data;
    logic          o_tx_data_valid;
    logic          i_xfer_active = 1'b0;
    logic          i_seq_mode = 1'b0;
    logic          o_irq;
    int            n_mismatch = 0;
    int            tests_run = 0;
    int            n_cycles = 0;
    logic [31:0]   rd_val;

    spi_rx_status #(.DATA_W(DW), .DEPTH(DP)) dut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
        .i_rx_push(i_rx_push), .i_rx_data(i_rx_data), .o_rx_ready(o_rx_ready),
        .i_tx_pop(i_tx_pop), .o_tx_avail(o_tx_avail), .o_tx_data(o_tx_data),
        .o_tx_data_valid(o_tx_data_valid), .i_xfer_active(i_xfer_active),
        .i_seq_mode(i_seq_mode), .o_irq(o_irq)
    );

    always #2.5 i_sys_clk = ~i_sys_clk;

    // A hang is cut short here
    always @(posedge i_sys_clk) begin
        n_cycles <= n_cycles + 1;
        if (n_cycles == MAX_CYC) begin
            n_mismatch = n_mismatch + 1;
            final_report();
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr    <= a;
        i_wr_data <= d;
        i_wr_stb  <= 1'b1;
        @(posedge i_sys_clk);
        i_wr_stb  <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr   <= a;
        i_rd_stb <= 1'b1;
        @(posedge i_sys_clk);
        i_rd_stb <= 1'b0;
        #1 d = o_rd_data;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        rd(a, rd_val);
        chk(rd_val, exp, what);
    endtask : rd_chk

    task automatic push(input logic [DW-1:0] d);
        @(posedge i_sys_clk);
        i_rx_push <= 1'b1;
        i_rx_data <= d;
        @(posedge i_sys_clk);
        i_rx_push <= 1'b0;
    endtask : push

    task automatic pop_chk(input logic [DW-1:0] exp);
        @(posedge i_sys_clk);
        i_tx_pop <= 1'b1;
        @(posedge i_sys_clk);
        i_tx_pop <= 1'b0;
        #1;
        chk({31'h0, o_tx_data_valid}, 32'h0000_0001, "tx valid");
        chk({16'h0, o_tx_data}, {16'h0, exp}, "tx word");
    endtask : pop_chk

    task automatic test_reset();
        rd_chk(8'h0c, 32'h0000_0005, "status at reset");
        rd_chk(8'h08, 32'h0000_0000, "read mode at reset");
        rd_chk(8'hfc, 32'h0000_0000, "unmapped read");
        chk({31'h0, o_irq}, 32'h0000_0000, "irq at reset");
    endtask : test_reset

    task automatic test_protect();
        wr(8'h08, 32'hffff_ffff);
        rd_chk(8'h08, 32'h0000_0001, "read mode bits");
        push(16'ha5a5);
        push(16'h5a5a);
        rd_chk(8'h0c, 32'h0000_0001, "status rx not empty");
        rd_chk(8'h00, 32'h0000_a5a5, "protected read 1");
        rd_chk(8'h00, 32'h0000_a5a5, "protected read 2");
        wr(8'h04, 32'h0000_0001);
        rd_chk(8'h00, 32'h0000_5a5a, "after pop");
        wr(8'h04, 32'h0000_0001);
        rd_chk(8'h0c, 32'h0000_0005, "status after pops");
        wr(8'h08, 32'h0000_0000);
    endtask : test_protect

    task automatic test_plain_read();
        push(16'h1234);
        push(16'h8765);
        rd_chk(8'h00, 32'h0000_1234, "plain read 1");
        rd_chk(8'h00, 32'h0000_8765, "plain read 2");
        rd_chk(8'h0c, 32'h0000_0005, "status after reads");
    endtask : test_plain_read

    task automatic test_rx_full_irq();
        wr(8'h10, 32'h0000_000f);
        wr(8'h14, 32'h0000_0001);
        for (int i = 0; i < DP; i++) begin
            push(16'hc000 + 16'(i));
        end
        rd_chk(8'h0c, 32'h0000_0009, "status rx full");
        chk({31'h0, o_rx_ready}, 32'h0000_0000, "rx ready when full");
        chk({31'h0, o_irq}, 32'h0000_0001, "irq on rx word");
        push(16'hdead);
        rd_chk(8'h10, 32'h0000_0003, "int status rx overrun");
        wr(8'h10, 32'h0000_0001);
        #1 chk({31'h0, o_irq}, 32'h0000_0000, "irq after clear");
        for (int i = 0; i < DP; i++) begin
            rd_chk(8'h00, 32'h0000_c000 + 32'(i), "drain order");
        end
        rd_chk(8'h0c, 32'h0000_0005, "status drained");
        wr(8'h14, 32'h0000_0000);
        wr(8'h10, 32'h0000_000f);
    endtask : test_rx_full_irq

    task automatic test_tx_status();
        for (int i = 0; i < DP; i++) begin
            wr(8'h00, 32'hffff_7000 + 32'(i));
        end
        rd_chk(8'h0c, 32'h0000_0016, "status tx full");
        chk({31'h0, o_tx_avail}, 32'h0000_0001, "tx avail when full");
        wr(8'h0c, 32'hffff_ffff);
        rd_chk(8'h0c, 32'h0000_0016, "status write ignored");
        wr(8'h00, 32'h0000_0bad);
        i_seq_mode <= 1'b1;
        rd_chk(8'h0c, 32'h0000_0036, "status sequential busy");
        for (int i = 0; i < DP; i++) begin
            pop_chk(16'h7000 + 16'(i));
        end
        chk({31'h0, o_tx_avail}, 32'h0000_0000, "tx avail when empty");
        @(posedge i_sys_clk);
        i_tx_pop <= 1'b1;
        @(posedge i_sys_clk);
        i_tx_pop <= 1'b0;
        #1 chk({31'h0, o_tx_data_valid}, 32'h0000_0000, "pop while empty");
        rd_chk(8'h0c, 32'h0000_0005, "status tx empty");
        rd_chk(8'h10, 32'h0000_000c, "int status tx");
        i_xfer_active <= 1'b1;
        rd_chk(8'h0c, 32'h0000_0035, "status busy transfer");
        i_seq_mode <= 1'b0;
        rd_chk(8'h0c, 32'h0000_0015, "status busy plain");
        i_xfer_active <= 1'b0;
        rd_chk(8'h0c, 32'h0000_0005, "status idle");
    endtask : test_tx_status

    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        test_reset();
        test_protect();
        test_plain_read();
        test_rx_full_irq();
        test_tx_status();
        final_report();
    end
endmodule : spi_rx_status_test

`default_nettype wire
